// ===== src/phe_pkg.sv
// constants for the packet header check code encoder and decoder
// assumes a four byte header: three data bytes then one check byte
package phe_pkg;
   localparam int DATA_W  = 24;
   localparam int CHK_W   = 8;
   localparam int USED_W  = 6;
   localparam int HDR_W   = 32;
   localparam logic [1:0] UNUSED_ZERO = 2'h0;
   localparam logic [5:0] SYN_ZERO    = 6'h00;
   localparam logic [23:0] DATA_ZERO  = 24'h000000;
   localparam logic [7:0]  CHK_ZERO   = 8'h00;
   // highest used check bit inside the four byte header
   localparam int          CHK_MSB    = 29;
   localparam logic [5:0]  SYN_LSB    = 6'h01;
   // syndrome matched no data column
   localparam logic [4:0]  POS_NONE   = 5'h18;
   // parity masks over data bits 0..23, one per used check bit
   localparam logic [23:0] MASK_P0 = 24'hF12CB7;
   localparam logic [23:0] MASK_P1 = 24'hF2555B;
   localparam logic [23:0] MASK_P2 = 24'h749A6D;
   localparam logic [23:0] MASK_P3 = 24'hB8E38E;
   localparam logic [23:0] MASK_P4 = 24'hDF03F0;
   localparam logic [23:0] MASK_P5 = 24'hEFFC00;
   // decoder state
   typedef enum logic [1:0] {
      PHE_IDLE  = 2'b01,
      PHE_VALID = 2'b10
   } phe_state_t;
endpackage

// ===== src/phe_parity.sv
// combinational check byte generator for 24 header data bits
// assumes callers register the result
`timescale 1ns/1ps
module phe_parity (
   // data in
   input  wire logic [23:0] i_data,
   // check byte out
   output logic      [7:0]  o_chk
);
   always_comb begin
      o_chk[0] = ^(i_data & phe_pkg::MASK_P0);
      o_chk[1] = ^(i_data & phe_pkg::MASK_P1);
      o_chk[2] = ^(i_data & phe_pkg::MASK_P2);
      o_chk[3] = ^(i_data & phe_pkg::MASK_P3);
      o_chk[4] = ^(i_data & phe_pkg::MASK_P4);
      o_chk[5] = ^(i_data & phe_pkg::MASK_P5);
      o_chk[7:6] = phe_pkg::UNUSED_ZERO;
   end
endmodule

// ===== src/phe_top.sv
// header check code encoder and single-correct double-detect decoder
// assumes framer and deframer logic on the same clock, valid strobes
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - check byte corrects any single-bit and detects any double-bit error.
// - returning peripheral also generates and sends the check byte.
// - one-way peripheral still corrects single-bit header errors.
// - code is a modified Hamming code, five plus one parity bits, 24 data.
// - header is four bytes: 24 data bits then eight check bits.
// - encoder drives the top two check bits to zero.
// - decoder zeroes the top two received check bits before syndrome.
// - zero syndrome passes header data unchanged, no error.
// - nonzero syndrome means at least one error, classify it.
// - syndrome equal to a data column marks that data bit in error.
// - syndrome with one bit set is a check bit error; data unchanged.
// - each check bit is XOR of a fixed data bit subset.
// - syndrome is received check XOR recomputed; matched bit is inverted.
// - unmatched nonzero syndrome sets the multi-bit error flag.
// - receiver recomputation uses the same zero padding as encoder.
module phe_top (
   // clock and reset
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST,
   // encoder request
   input  wire logic        I_ENC_VALID,
   input  wire logic [23:0] I_ENC_DATA,
   // encoder result
   output logic             O_ENC_VALID,
   output logic      [31:0] O_ENC_HDR,
   // decoder request
   input  wire logic        I_DEC_VALID,
   input  wire logic [31:0] I_DEC_HDR,
   // decoder result
   output logic             O_DEC_VALID,
   output logic      [31:0] O_DEC_HDR,
   output logic             O_DEC_CORRECTED,
   output logic             O_DEC_MULTI_ERR
);
   ////////////////////////////////////////////////////////////////////////////
   // functions
   // syndrome column of one data bit, taken from the parity masks
   function automatic logic [5:0] data_col(input int k);
      logic [5:0] c;
      c[0] = phe_pkg::MASK_P0[k];
      c[1] = phe_pkg::MASK_P1[k];
      c[2] = phe_pkg::MASK_P2[k];
      c[3] = phe_pkg::MASK_P3[k];
      c[4] = phe_pkg::MASK_P4[k];
      c[5] = phe_pkg::MASK_P5[k];
      return c;
   endfunction

   // syndrome to data bit position; no match gives the none code
   function automatic logic [4:0] syn_to_pos(input logic [5:0] s);
      logic [4:0] p;
      p = phe_pkg::POS_NONE;
      for (int k = 0; k < phe_pkg::DATA_W; k++) begin
         if (data_col(k) == s) begin
            p = 5'(k);
         end
      end
      return p;
   endfunction

   // nonzero with one bit set: a check bit took the hit
   function automatic logic one_hot6(input logic [5:0] s);
      return (s != phe_pkg::SYN_ZERO) && ((s & (s - phe_pkg::SYN_LSB)) == phe_pkg::SYN_ZERO);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // shared parity generators
   logic [7:0] enc_chk;
   logic [7:0] dec_chk;
   phe_parity u_enc_par (
      .i_data (I_ENC_DATA),
      .o_chk  (enc_chk)
   );
   phe_parity u_dec_par (
      .i_data (I_DEC_HDR[23:0]),
      .o_chk  (dec_chk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // encoder
   logic        enc_valid_reg;
   logic [31:0] enc_hdr_reg;
   logic [31:0] enc_hdr_next;

   // check byte sits above the three data bytes
   always_comb begin
      enc_hdr_next = {enc_chk, I_ENC_DATA};
   end

   // one result strobe per accepted request
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         enc_valid_reg <= 1'b0;
      end else begin
         enc_valid_reg <= I_ENC_VALID;
      end
   end

   // header holds until the next request
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         enc_hdr_reg <= {phe_pkg::CHK_ZERO, phe_pkg::DATA_ZERO};
      end else if (I_ENC_VALID) begin
         enc_hdr_reg <= enc_hdr_next;
      end
   end

   assign O_ENC_VALID = enc_valid_reg;
   assign O_ENC_HDR   = enc_hdr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // decoder: syndrome
   logic [7:0]  rx_chk;
   logic [5:0]  syn;
   logic [4:0]  pos;
   always_comb begin
      rx_chk = {phe_pkg::UNUSED_ZERO, I_DEC_HDR[phe_pkg::CHK_MSB:phe_pkg::DATA_W]};
      syn    = rx_chk[5:0] ^ dec_chk[5:0];
      pos    = syn_to_pos(syn);
   end

   // decoder: classify the syndrome
   logic        syn_chk;
   logic        syn_data;
   logic        syn_multi;
   always_comb begin
      syn_chk   = 1'b0;
      syn_data  = 1'b0;
      syn_multi = 1'b0;
      if (syn == phe_pkg::SYN_ZERO) begin
         syn_multi = 1'b0;
      end else if (one_hot6(syn)) begin
         syn_chk = 1'b1;
      end else if (pos != phe_pkg::POS_NONE) begin
         syn_data = 1'b1;
      end else begin
         syn_multi = 1'b1;
      end
   end

   // decoder: correction and flags
   logic [23:0] fixed_data;
   logic [31:0] dec_hdr_next;
   logic        corr_next;
   logic        multi_next;
   always_comb begin
      fixed_data = I_DEC_HDR[phe_pkg::DATA_W-1:0];
      if (syn_data) begin
         fixed_data[pos] = ~I_DEC_HDR[pos];
      end
      dec_hdr_next = {rx_chk, fixed_data};
      corr_next    = syn_chk | syn_data;
      multi_next   = syn_multi;
   end

   // decoder: result strobe follows each request by one cycle
   phe_pkg::phe_state_t st_reg;
   phe_pkg::phe_state_t st_next;
   always_comb begin
      case (st_reg)
         phe_pkg::PHE_IDLE: begin
            st_next = I_DEC_VALID ? phe_pkg::PHE_VALID : phe_pkg::PHE_IDLE;
         end
         phe_pkg::PHE_VALID: begin
            st_next = I_DEC_VALID ? phe_pkg::PHE_VALID : phe_pkg::PHE_IDLE;
         end
         default: begin
            st_next = phe_pkg::PHE_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         st_reg <= phe_pkg::PHE_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   logic [31:0] dec_hdr_reg;
   logic        dec_corr_reg;
   logic        dec_multi_reg;

   // corrected data, received check bits with the top two cleared
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         dec_hdr_reg <= {phe_pkg::CHK_ZERO, phe_pkg::DATA_ZERO};
      end else if (I_DEC_VALID) begin
         dec_hdr_reg <= dec_hdr_next;
      end
   end

   // single error corrected flag, held until the next request
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         dec_corr_reg <= 1'b0;
      end else if (I_DEC_VALID) begin
         dec_corr_reg <= corr_next;
      end
   end

   // uncorrectable flag, held until the next request
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         dec_multi_reg <= 1'b0;
      end else if (I_DEC_VALID) begin
         dec_multi_reg <= multi_next;
      end
   end

   assign O_DEC_VALID     = (st_reg == phe_pkg::PHE_VALID);
   assign O_DEC_HDR       = dec_hdr_reg;
   assign O_DEC_CORRECTED = dec_corr_reg;
   assign O_DEC_MULTI_ERR = dec_multi_reg;
endmodule

// ===== dv/phe_framer_model.sv
// reference framer: appends the check byte to three header data bytes
// assumes a combinational consumer in the bench
`timescale 1ns/1ps
module phe_framer_model (
   // header data
   input  wire logic [23:0] i_data,
   // four byte header
   output logic      [31:0] o_hdr
);
   // syndrome column of each data bit, data bit 0 in the low byte
   localparam logic [191:0] COLS = {
      48'h3B372F1F3834, 48'h32312C2A2926, 48'h25231C1A1916, 48'h15130E0D0B07};
   always_comb begin
      o_hdr = {8'h00, i_data};
      for (int i = 0; i < 24; i++)
         if (i_data[i]) o_hdr[29:24] ^= COLS[i*8 +: 6];
   end
endmodule

// ===== dv/phe_top_sva.sv
// port checker for the header check code block
// assumes one clock domain and a bind onto phe_top
`timescale 1ns/1ps
module phe_top_chk (
   input wire logic        I_REF_CLK,
   input wire logic        I_RST,
   input wire logic        I_ENC_VALID,
   input wire logic [23:0] I_ENC_DATA,
   input wire logic        O_ENC_VALID,
   input wire logic [31:0] O_ENC_HDR,
   input wire logic        I_DEC_VALID,
   input wire logic [31:0] I_DEC_HDR,
   input wire logic        O_DEC_VALID,
   input wire logic [31:0] O_DEC_HDR,
   input wire logic        O_DEC_CORRECTED,
   input wire logic        O_DEC_MULTI_ERR
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);
   sequence dec_req; I_DEC_VALID; endsequence
   sequence dec_ok; O_DEC_VALID && !O_DEC_CORRECTED && !O_DEC_MULTI_ERR; endsequence
   enc_lat_a: assert property (I_ENC_VALID |=> O_ENC_VALID
      && O_ENC_HDR[23:0] == $past(I_ENC_DATA)) else $error("encoder result wrong");
   enc_idle_a: assert property (!I_ENC_VALID |=> !O_ENC_VALID)
      else $error("encoder valid unrequested");
   enc_top_a: assert property (O_ENC_VALID |-> O_ENC_HDR[31:30] == 2'h0)
      else $error("encoder top bits set");
   dec_lat_a: assert property (dec_req |=> O_DEC_VALID)
      else $error("decoder result missing");
   dec_idle_a: assert property (!I_DEC_VALID |=> !O_DEC_VALID)
      else $error("decoder valid unrequested");
   dec_top_a: assert property (dec_req |=> O_DEC_HDR[31:24] ==
      {2'h0, $past(I_DEC_HDR[29:24])}) else $error("decoder check byte wrong");
   dec_pass_a: assert property (dec_req ##1 dec_ok |->
      O_DEC_HDR[23:0] == $past(I_DEC_HDR[23:0])) else $error("clean header altered");
   flag_excl_a: assert property (O_DEC_VALID |-> !(O_DEC_CORRECTED && O_DEC_MULTI_ERR))
      else $error("both flags set");
   rst_clr_a: assert property (disable iff (1'b0) I_RST |=> !O_ENC_VALID && !O_DEC_VALID
      && O_ENC_HDR == 32'h00000000 && O_DEC_HDR == 32'h00000000
      && !O_DEC_CORRECTED && !O_DEC_MULTI_ERR) else $error("outputs not cleared by reset");
endmodule
bind phe_top phe_top_chk i_chk (.*);

// ===== dv/packet_header_ecc_tb.sv
// self-checking bench for the header check code block
// assumes the framer model as reference and queued expectations
`timescale 1ns/1ps
module packet_header_ecc_tb;
   logic        clk = 1'b0, rst = 1'b1, enc_v = 1'b0, dec_v = 1'b0;
   logic        o_ev, o_dv, o_corr, o_multi;
   logic [23:0] enc_d = 24'h000000, nxt_d = 24'h000000;
   logic [31:0] dec_h = 32'h00000000, flip, o_eh, o_dh, good_h;
   logic [31:0] lfsr_q = 32'hDCF2C63B;
   logic [31:0] enc_q[$];
   logic [33:0] dec_q[$];
   int          bad_count = 0, samples_checked = 0, cyc = 0, m;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
      samples_checked++;
      if (exp !== got) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report();
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial forever #10 clk = ~clk;
   phe_framer_model i_model (.i_data(nxt_d), .o_hdr(good_h));
   phe_top i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_ENC_VALID(enc_v), .I_ENC_DATA(enc_d),
      .O_ENC_VALID(o_ev), .O_ENC_HDR(o_eh), .I_DEC_VALID(dec_v), .I_DEC_HDR(dec_h),
      .O_DEC_VALID(o_dv), .O_DEC_HDR(o_dh), .O_DEC_CORRECTED(o_corr),
      .O_DEC_MULTI_ERR(o_multi));
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      for (int n = 0; n < 240; n++) begin
         @(posedge clk);
         #1;
         m = n % 4;
         flip = 32'h00000000;
         // 1 data bit, 2 check bit, 3 two adjacent data bits
         if (m == 1) flip[n % 24] = 1'b1;
         if (m == 2) flip[24 + n % 6] = 1'b1;
         if (m == 3) flip = 32'h00000003 << (n % 23);
         flip[31:30] = lfsr_q[31:30];
         enc_v = (n % 7 != 6);
         dec_v = enc_v;
         enc_d = nxt_d;
         dec_h = good_h ^ flip;
         if (enc_v) begin
            enc_q.push_back(good_h);
            dec_q.push_back({2'h0, dec_h[29:24], m == 3 ? dec_h[23:0] : good_h[23:0],
               m == 1 || m == 2, m == 3});
         end
         lfsr_q = lfsr(lfsr_q);
         nxt_d = lfsr_q[23:0];
      end
      @(posedge clk);
      #1 enc_v = 1'b0;
      dec_v = 1'b0;
      repeat (3) @(posedge clk);
      chk("enc_left", 34'h0, 34'(enc_q.size()));
      chk("dec_left", 34'h0, 34'(dec_q.size()));
      final_report();
   end
   always @(posedge clk) begin
      #2;
      if (o_ev === 1'b1) chk("enc_hdr", {2'h0, enc_q.pop_front()}, {2'h0, o_eh});
      if (o_dv === 1'b1) chk("dec_out", dec_q.pop_front(), {o_dh, o_corr, o_multi});
      cyc++;
      if (cyc > 2000) begin
         bad_count++;
         final_report();
      end
   end
endmodule
